// File: pkg/reset_nmi_consts.svh
/*
 * constants for the reset / non-maskable event control block.
 * assumes a 100 MHz cpu clock; the filter count is derived from the times below.
 */
`ifndef RESET_NMI_CONSTS_SVH
`define RESET_NMI_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define SPIKE_MAX_NS 10
`define SAFE_LOW_NS 100
// least time rounds up, then the two cpu clocks on top
`define SAFE_LOW_CYC ((`SAFE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 2)
`define SEQ_LEN_DEF 1024
`define RECOMMENDED_HOLD_US 1000
`define CFG_WIDTH 16
`define BOOT_STRAP_BIT 4
`define CFG_RESET_VAL 16'h0000

`endif

// File: pkg/reset_nmi_pkg.sv
/*
 * types for the reset / non-maskable event control block.
 * assumes nothing beyond the constants header.
 */
package reset_nmi_pkg;

   // sequencer states, gray coded along seq->init_wait->run
   typedef enum logic [1:0] {
      ST_SEQ = 2'b00,
      ST_INIT_WAIT = 2'b01,
      ST_RUN = 2'b11,
      ST_HOLD = 2'b10
   } seq_state_e;

   typedef enum logic [1:0] {
      SRC_NONE = 2'b00,
      SRC_HW_LONG = 2'b01,
      SRC_SW = 2'b10,
      SRC_WDT = 2'b11
   } reset_src_e;

   // reset indication flags seen by software
   typedef struct packed {
      logic hw_long;
      logic sw;
      logic wdt;
   } reset_flags_s;

endpackage

// File: core/reset_nmi_powerdown_control.sv
/*
 * reset sequencing, bidirectional reset line, reset indication output,
 * non-maskable event edge detect and power-down gating.
 * assumes all pin inputs synchronous to sys_clk_in; the oscillator runs
 * whenever the clock toggles, so a reset pin sampled low for 12 cycles in a row means a reset.
 */
`timescale 1ns/100ps
`include "reset_nmi_consts.svh"

module reset_nmi_powerdown_control #(
   parameter int SEQ_LEN = `SEQ_LEN_DEF,
   parameter int CFG_W = `CFG_WIDTH
) (
   input wire logic sys_clk_in, // 100 MHz cpu clock
   input wire logic reset_in, // async power-on reset, active high
   input wire logic reset_input_pin_in, // level of the reset line
   output logic reset_input_pin_out, // value driven on reset line (always 0)
   output logic reset_input_pin_oe_out, // high while pulling the line low
   output logic reset_indication_output_n_out, // low during reset until init end
   output logic cpu_reset_out, // internal reset to the core
   input wire logic sw_reset_in, // software reset pulse
   input wire logic wdt_reset_in, // watchdog reset pulse
   input wire logic end_of_init_instruction_in, // end of init executed, pulse
   input wire logic bidir_reset_enable_wr_in, // write strobe for the enable bit
   input wire logic bidir_reset_enable_wdata_in, // value written
   output logic bidir_reset_enable_out, // current enable bit
   output reset_nmi_pkg::reset_flags_s reset_flags_out, // reset source flags
   input wire logic [CFG_W-1:0] reset_config_port_in, // configuration strap port
   output logic [CFG_W-1:0] reset_config_out, // sampled configuration
   output logic bootstrap_enter_out, // bootstrap loader selected
   input wire logic nmi_pin_in, // non-maskable event pin
   output logic nmi_trap_out, // one-cycle trap request
   input wire logic power_down_instruction_in, // power-down executed, pulse
   output logic power_down_out // power-down mode active
);

   localparam int CNT_W = $clog2(SEQ_LEN + 1);
   localparam int FLT_W = $clog2(`SAFE_LOW_CYC + 1);
   // saturates one short: the low sample that meets it completes the safe span
   localparam logic [FLT_W-1:0] FLT_MAX = FLT_W'(`SAFE_LOW_CYC - 1);
   localparam logic [CNT_W-1:0] SEQ_LAST = CNT_W'(SEQ_LEN - 1);

   reset_nmi_pkg::seq_state_e state_q, state_d;
   logic [CNT_W-1:0] seq_cnt_q;
   logic [FLT_W-1:0] low_cnt_q;
   logic bidir_q;
   logic init_done_q;
   logic nmi_prev_q;
   logic pd_q;
   logic drive_q;
   logic ind_n_q;
   logic cpu_rst_q;
   logic boot_q;
   logic [CFG_W-1:0] cfg_q;
   reset_nmi_pkg::reset_flags_s flags_q;

   // glitch filter
   // the pin is only seen while low for the full safe count; shorter lows vanish
   wire pin_low = !reset_input_pin_in;
   // our own pull is no outside request; counting it would restart the sequence forever
   wire ext_low = pin_low && !drive_q;
   wire hw_reset = ext_low && (low_cnt_q == FLT_MAX);
   // reset entry
   // any source restarts the internal sequence, except while in ST_HOLD
   wire any_reset = hw_reset || sw_reset_in || wdt_reset_in;
   wire seq_done = (state_q == reset_nmi_pkg::ST_SEQ) && (seq_cnt_q == SEQ_LAST);
   // stretch short reset
   // in bidirectional mode the sequence runs out even if the pin rises early
   wire hold_pin = hw_reset && !bidir_q;
   wire nmi_fall = nmi_prev_q && !nmi_pin_in;
   wire bidir_wr = bidir_reset_enable_wr_in && !init_done_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         reset_nmi_pkg::ST_SEQ: begin
            if (seq_done)
               state_d = hold_pin ? reset_nmi_pkg::ST_HOLD : reset_nmi_pkg::ST_INIT_WAIT;
         end
         reset_nmi_pkg::ST_HOLD: begin
            if (!pin_low)
               state_d = reset_nmi_pkg::ST_INIT_WAIT;
         end
         reset_nmi_pkg::ST_INIT_WAIT: begin
            if (end_of_init_instruction_in)
               state_d = reset_nmi_pkg::ST_RUN;
         end
         reset_nmi_pkg::ST_RUN: state_d = reset_nmi_pkg::ST_RUN;
         default: state_d = reset_nmi_pkg::ST_SEQ;
      endcase
      if (any_reset && state_q != reset_nmi_pkg::ST_HOLD)
         state_d = reset_nmi_pkg::ST_SEQ;
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         low_cnt_q <= '0;
         nmi_prev_q <= 1'b1;
      end else begin
         low_cnt_q <= ext_low ? ((low_cnt_q == FLT_MAX) ? FLT_MAX : low_cnt_q + 1'b1) : '0;
         nmi_prev_q <= nmi_pin_in;
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= reset_nmi_pkg::ST_SEQ;
         seq_cnt_q <= '0;
      end else begin
         state_q <= state_d;
         seq_cnt_q <= (state_d == reset_nmi_pkg::ST_SEQ && !seq_done && !any_reset) ?
                      seq_cnt_q + 1'b1 : '0;
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         bidir_q <= 1'b0;
         init_done_q <= 1'b0;
      end else if (any_reset) begin
         bidir_q <= 1'b0;
         init_done_q <= 1'b0;
      end else begin
         if (bidir_wr)
            bidir_q <= bidir_reset_enable_wdata_in;
         if (end_of_init_instruction_in && state_q == reset_nmi_pkg::ST_INIT_WAIT)
            init_done_q <= 1'b1;
      end
   end

   // flags and straps are taken at the reset edge itself, before the enable clears
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         flags_q <= '{hw_long: 1'b1, sw: 1'b0, wdt: 1'b0};
         cfg_q <= CFG_W'(`CFG_RESET_VAL);
         boot_q <= 1'b0;
      end else begin
         if (any_reset) begin
            // forced long flag
            // bidir_q is still the pre-reset value here, it is cleared this edge
            flags_q.hw_long <= hw_reset || bidir_q;
            flags_q.sw <= sw_reset_in && !hw_reset && !bidir_q;
            flags_q.wdt <= wdt_reset_in && !hw_reset && !sw_reset_in && !bidir_q;
         end
         if (any_reset && (hw_reset || bidir_q)) begin
            cfg_q <= reset_config_port_in;
            boot_q <= !reset_config_port_in[`BOOT_STRAP_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         drive_q <= 1'b0;
         ind_n_q <= 1'b0;
         cpu_rst_q <= 1'b1;
         pd_q <= 1'b0;
      end else begin
         // drive line low
         // held for the whole sequence after any source while enabled
         drive_q <= (bidir_q || drive_q) && state_d == reset_nmi_pkg::ST_SEQ;
         ind_n_q <= state_d == reset_nmi_pkg::ST_RUN;
         cpu_rst_q <= state_d == reset_nmi_pkg::ST_SEQ || state_d == reset_nmi_pkg::ST_HOLD;
         // power-down gate
         // only a reset leaves power-down; the pin level matters only at entry
         if (any_reset)
            pd_q <= 1'b0;
         else if (power_down_instruction_in && !nmi_pin_in)
            pd_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in)
         nmi_trap_out <= 1'b0;
      else
         nmi_trap_out <= nmi_fall && !cpu_rst_q;
   end

   assign reset_input_pin_out = 1'b0;
   assign reset_input_pin_oe_out = drive_q;
   assign reset_indication_output_n_out = ind_n_q;
   assign cpu_reset_out = cpu_rst_q;
   assign bidir_reset_enable_out = bidir_q;
   assign reset_flags_out = flags_q;
   assign reset_config_out = cfg_q;
   assign bootstrap_enter_out = boot_q;
   assign power_down_out = pd_q;

   a_filter_recog: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ((!reset_input_pin_in && !reset_input_pin_oe_out) [*8] ##1
      (!reset_input_pin_in && !reset_input_pin_oe_out) [*4]) |=>
      (state_q == reset_nmi_pkg::ST_SEQ || state_q == reset_nmi_pkg::ST_HOLD))
      else $error("held low reset pin did not reset");
   a_spike_ignored: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (!cpu_reset_out && reset_input_pin_in && !sw_reset_in && !wdt_reset_in)
      ##1 (!reset_input_pin_in && !sw_reset_in && !wdt_reset_in) ##1 reset_input_pin_in
      |-> !cpu_reset_out)
      else $error("single-cycle reset spike was not filtered");
   a_drive_bidir: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (bidir_q && sw_reset_in) |=> reset_input_pin_oe_out [*4])
      else $error("reset line not driven after reset in bidirectional mode");
   a_ind_until_init: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(reset_indication_output_n_out) |-> $past(end_of_init_instruction_in))
      else $error("reset indication released without end of init");
   a_nmi_trap: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ($fell(nmi_pin_in) && !cpu_rst_q) |=> nmi_trap_out)
      else $error("falling edge did not raise trap");
   a_pd_gate: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (power_down_instruction_in && !any_reset && !pd_q) |=>
      (power_down_out == !$past(nmi_pin_in)))
      else $error("power-down gating by event pin wrong");
   a_bidir_lock: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (init_done_q && !any_reset) |=> $stable(bidir_q))
      else $error("bidirectional enable changed after end of init");
   a_flags_long: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (bidir_q && any_reset) |=> (reset_flags_out.hw_long && !reset_flags_out.sw))
      else $error("flags not forced to long hardware reset");
   a_boot_strap: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (bidir_q && any_reset) |=>
      bootstrap_enter_out == !$past(reset_config_port_in[`BOOT_STRAP_BIT]))
      else $error("bootstrap select not sampled");
   a_stretch: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (bidir_q && hw_reset) |=> cpu_reset_out [*8])
      else $error("short hardware reset not stretched");

endmodule

// File: test/reset_far_side.sv
/*
 * far side of the reset line and the event pin: a supervisor that may pull
 * the open-drain reset line low, and a board event source.
 * assumes the line has a pull-up, so a released line reads high.
 */
`timescale 1ns/100ps

module reset_far_side (
   input wire logic dev_oe_in, // device pulls line low
   input wire logic pull_req_in, // bench asks supervisor to pull low
   input wire logic event_req_in, // bench level for the event pin
   output logic line_out, // resolved reset line level
   output logic event_out // event pin level
);
   // supervisor hold length
   // the bench sets how long the supervisor holds the line low
   assign line_out = (dev_oe_in | pull_req_in) ? 1'b0 : 1'b1;
   assign event_out = event_req_in;
endmodule

// File: test/reset_nmi_powerdown_control_tb_top.sv
/*
 * self-checking bench for the reset / event control block.
 * assumes the reset line and the event pin come from reset_far_side.
 */
`timescale 1ns/100ps

module reset_nmi_powerdown_control_tb_top;
   localparam int SEQ = 16;
   logic sys_clk_in = 1'b0, reset_in = 1'b1, sw = 1'b0, wdt = 1'b0, eoi = 1'b0;
   logic bwr = 1'b0, bwd = 1'b0, pull = 1'b0, ev = 1'b1, pd_in = 1'b0;
   logic [15:0] cfg = 16'h0000;
   logic line, ev_pin, pin_o, oe, ind_n, cpu, bdr, boot, trap, pd;
   logic [15:0] cfg_o;
   reset_nmi_pkg::reset_flags_s flags;
   logic note_q[$];
   int fails = 0, total_checks = 0, n, seed = 32'h74EC;

   initial forever #5 sys_clk_in = ~sys_clk_in;

   reset_far_side far (.dev_oe_in(oe), .pull_req_in(pull), .event_req_in(ev),
      .line_out(line), .event_out(ev_pin));

   reset_nmi_powerdown_control #(.SEQ_LEN(SEQ)) DUT (.sys_clk_in(sys_clk_in),
      .reset_in(reset_in), .reset_input_pin_in(line), .reset_input_pin_out(pin_o),
      .reset_input_pin_oe_out(oe), .reset_indication_output_n_out(ind_n),
      .cpu_reset_out(cpu), .sw_reset_in(sw), .wdt_reset_in(wdt),
      .end_of_init_instruction_in(eoi), .bidir_reset_enable_wr_in(bwr),
      .bidir_reset_enable_wdata_in(bwd), .bidir_reset_enable_out(bdr),
      .reset_flags_out(flags), .reset_config_port_in(cfg), .reset_config_out(cfg_o),
      .bootstrap_enter_out(boot), .nmi_pin_in(ev_pin), .nmi_trap_out(trap),
      .power_down_instruction_in(pd_in), .power_down_out(pd));

   task automatic chk(input logic got, input logic exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask

   task automatic step;
      @(negedge sys_clk_in);
   endtask

   task automatic wait_run;
      n = 0;
      while (cpu !== 1'b0 && n < 200) begin
         step;
         n++;
      end
      chk(cpu, 1'b0, "core reset never released");
   endtask

   task automatic end_sim;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // each trap seen takes the oldest note
   always @(negedge sys_clk_in) begin
      if (trap === 1'b1) begin
         if (note_q.size() == 0) chk(1'b1, 1'b0, "unexpected trap");
         else chk(trap, note_q.pop_front(), "trap mismatch");
      end
   end

   initial begin
      #200000;
      fails++;
      end_sim;
   end

   initial begin
      repeat (6) step;
      reset_in = 1'b0;
      chk(ind_n, 1'b0, "indication high in reset");
      wait_run;
      bwd = 1'b1;
      bwr = 1'b1;
      step;
      bwr = 1'b0;
      chk(bdr, 1'b1, "enable write lost");
      eoi = 1'b1;
      step;
      eoi = 1'b0;
      chk(ind_n, 1'b1, "indication stuck low");
      bwd = 1'b0;
      bwr = 1'b1;
      step;
      bwr = 1'b0;
      chk(bdr, 1'b1, "enable changed after init");
      cfg = 16'($random(seed)) & 16'hFFEF;
      sw = 1'b1;
      step;
      sw = 1'b0;
      chk(cpu, 1'b1, "software reset ignored");
      chk(bdr, 1'b0, "enable not cleared");
      chk(flags.hw_long, 1'b1, "flags not long reset");
      n = 1;
      while (oe === 1'b1 && n < 100) begin
         step;
         if (oe === 1'b1) n++;
      end
      chk16(16'(n), 16'(SEQ), "line pull length");
      chk16(cfg_o, cfg, "config not sampled");
      chk(boot, 1'b1, "bootstrap not selected");
      chk(ind_n, 1'b0, "indication high before init");
      wait_run;
      pull = 1'b1;
      step;
      pull = 1'b0;
      step;
      chk(cpu, 1'b0, "one-cycle spike passed filter");
      pull = 1'b1;
      repeat (11) step;
      pull = 1'b0;
      repeat (3) step;
      chk(cpu, 1'b0, "short pulse passed filter");
      pull = 1'b1;
      repeat (12) step;
      pull = 1'b0;
      repeat (2) step;
      chk(cpu, 1'b1, "pin reset missed");
      wait_run;
      wdt = 1'b1;
      step;
      wdt = 1'b0;
      chk(flags.wdt, 1'b1, "watchdog flag missing");
      wait_run;
      cfg = 16'($random(seed)) | 16'h0010;
      bwd = 1'b1;
      bwr = 1'b1;
      step;
      bwr = 1'b0;
      pull = 1'b1;
      repeat (12) step;
      pull = 1'b0;
      chk(cpu, 1'b1, "bidir pin reset missed");
      n = 1;
      while (oe === 1'b1 && n < 100) begin
         step;
         if (oe === 1'b1) n++;
      end
      chk16(16'(n), 16'(SEQ), "short pin reset not stretched");
      chk(flags.hw_long, 1'b1, "pin reset flag missing");
      chk(flags.sw, 1'b0, "software flag after pin reset");
      chk16(cfg_o, cfg, "config not sampled on pin reset");
      chk(boot, 1'b0, "bootstrap with strap high");
      chk(bdr, 1'b0, "enable not cleared by pin reset");
      wait_run;
      ev = 1'b0;
      note_q.push_back(1'b1);
      repeat (3) step;
      ev = 1'b1;
      step;
      pd_in = 1'b1;
      step;
      pd_in = 1'b0;
      step;
      chk(pd, 1'b0, "power-down with pin high");
      ev = 1'b0;
      note_q.push_back(1'b1);
      step;
      pd_in = 1'b1;
      step;
      pd_in = 1'b0;
      step;
      chk(pd, 1'b1, "power-down not taken");
      repeat (3) step;
      chk(note_q.size() == 0, 1'b1, "trap missing");
      end_sim;
   end
endmodule
